// ### rtl/usb_esc_pkg.sv
package usb_esc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80;
  localparam logic [7:0] ADDR_ERR_FLAGS = 8'h88;
  localparam logic [7:0] ADDR_ERREN = 8'h8C;
  localparam logic [7:0] ADDR_STAT = 8'h90;
  localparam logic [7:0] ADDR_CTL = 8'h94;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] ERREN_RESET = 8'h00;
  localparam logic [7:0] ERR_FLAGS_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] ERR_MASK = 8'hBF;
  localparam int STAT_DEPTH = 4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IRQ_STATUS_ERROR = 1;
  localparam int IRQ_STATUS_TOK_DONE = 3;
  localparam int CTL_J = 7;
  localparam int CTL_SE0 = 6;
  localparam int CTL_BUSY = 5;
  localparam int CTL_RESET_SIG = 4;
  localparam int CTL_HOST = 3;
  localparam int CTL_RESUME = 2;
  localparam int CTL_BANK_CLR = 1;
  localparam int CTL_ENABLE = 0;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // One transaction status entry.
  typedef struct packed {
    logic [3:0] endpoint;
    logic tx;
    logic odd;
  } stat_entry_t;

endpackage : usb_esc_pkg

// ### rtl/usb_error_status_control.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module usb_error_status_control #(
  parameter int DEPTH = usb_esc_pkg::STAT_DEPTH
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire usb_esc_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Serial engine events.
  input wire logic [7:0] err_event,
  input wire logic stat_push,
  input wire usb_esc_pkg::stat_entry_t stat_in,
  input wire logic token_busy,
  input wire logic setup_rx,
  // Receiver levels and speed.
  input wire logic rx_j_raw,
  input wire logic rx_se0,
  input wire logic low_speed_select,
  // Status and interrupt outputs.
  output logic stat_full,
  output logic error_irq,
  output logic token_done_flag,
  // Engine controls.
  output logic host_role_select,
  output logic drive_usb_reset,
  output logic drive_resume,
  output logic ls_eop_pulse,
  output logic bank_select_clear,
  output logic engine_reset_pulse,
  output logic module_enable_frame_gen,
  output logic sof_enable,
  output logic traffic_halt,
  output logic low_speed_token
);

  // ****************************************
  // Structure
  // ****************************************

  // The block sits between the register port and the serial engine. It
  // keeps three things: the error flags with their enable bank, the
  // transaction status queue, and the control register with the engine
  // control levels and pulses that follow from it.
  //
  // Every output is registered, so each level other than host_role_select, which is the mode bit
  // itself, reaches the engine one cycle after the bit that drives it is stored. Software times bus
  // reset and resume itself; the block only holds the level.
  //
  // The status queue stores one entry per descriptor use. Its head is what
  // a status read shows, and clearing token done moves the head on. An
  // entry that arrives while the queue is full and no pop is under way is
  // dropped; the engine is expected to pace itself against stat_full.
  //
  // The queue storage has no reset. A status read before the first push
  // returns whatever the storage holds, which is harmless because token
  // done is low then and software has no reason to read.

  // Pointer and occupancy widths. A depth of one still needs a one bit
  // pointer, hence the guard.
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  // ****************************************
  // Register state
  // ****************************************
  // Software visible bits. The J level is the receiver pin flipped by the low speed
  // setting, and the single ended zero level a copy of its pin, both taken once per clock.
  logic [7:0] error_irq_enable;
  logic [7:0] error_flag_register;
  logic live_j_level;
  logic live_se0;
  logic busy_or_suspend_flag;
  logic reset_bit;
  logic resume_bit;
  logic enable_bit;

  // Status queue storage. Pointers wrap at the last entry; the count
  // tells a full queue from an empty one, since the pointers alone cannot.
  usb_esc_pkg::stat_entry_t queue [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ****************************************
  // Address decode
  // ****************************************
  // Decoded write strobes and the queue handshake.
  logic wr_irq_status;
  logic wr_err_flags;
  logic wr_erren;
  logic wr_ctl;
  logic pop;
  logic push_ok;

  // Write strobes for each mapped register. Writes to unmapped offsets and
  // to the read-only status offset decode to nothing and are dropped.
  assign wr_irq_status = reg_req.wr &&
                         (reg_req.addr == usb_esc_pkg::ADDR_IRQ_STATUS);
  assign wr_err_flags = reg_req.wr &&
                        (reg_req.addr == usb_esc_pkg::ADDR_ERR_FLAGS);
  assign wr_erren = reg_req.wr && (reg_req.addr == usb_esc_pkg::ADDR_ERREN);
  assign wr_ctl = reg_req.wr && (reg_req.addr == usb_esc_pkg::ADDR_CTL);

  // ****************************************
  // Error flags and enables
  // ****************************************

  // Enable bank; bit 6 is masked so it can never be stored.
  // Only the enable bits are kept here; the flags sit in their own
  // register so that a write here never touches a pending error.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_irq_enable <= usb_esc_pkg::ERREN_RESET;
    end else if (wr_erren) begin
      error_irq_enable <= reg_req.wdata & usb_esc_pkg::ERR_MASK;
    end
  end

  // Flags set on the detecting cycle; a set beats a write-one clear.
  // A flag that is set and cleared in the same cycle stays set, so an
  // error that arrives during the clear is never lost.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_flag_register <= usb_esc_pkg::ERR_FLAGS_RESET;
    end else begin
      error_flag_register <=
        (error_flag_register & ~(wr_err_flags ? reg_req.wdata : 8'h00)) |
        (err_event & usb_esc_pkg::ERR_MASK);
    end
  end

  // Gated request, refreshed every clock.
  // The request lags the flags by one cycle; software that clears a flag
  // and then polls the request must allow for that.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      error_irq <= 1'b0;
    end else begin
      error_irq <= |(error_flag_register & error_irq_enable);
    end
  end

  // ****************************************
  // Transaction status queue
  // ****************************************

  // A pop needs the flag set, so a stray write cannot skip an entry. Only
  // the token done bit of the write pops; its other bits are ignored here.
  assign pop = wr_irq_status &&
               reg_req.wdata[usb_esc_pkg::IRQ_STATUS_TOK_DONE] &&
               token_done_flag;
  // A pop in the same cycle frees a slot, so a full queue still accepts.
  assign push_ok = stat_push && ((count != FULL) || pop);

  // Occupancy after this cycle's push and pop.
  always_comb begin
    next_count = count;
    if (push_ok && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push_ok) begin
      next_count = count - CW'(1);
    end
  end

  // Entry storage, written at the tail.
  always_ff @(posedge clk_sys) begin
    if (push_ok) begin
      queue[wr_ptr] <= stat_in;
    end
  end

  // Tail pointer. It only moves when an entry is really taken, so a
  // dropped push leaves it where it was.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (push_ok) begin
      wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
    end
  end

  // Head pointer moves on to the next entry when software clears the flag.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
    end
  end

  // Count and the flags derived from it.
  // Token done is taken from the next count, so it rises in the cycle
  // after a push into an empty queue and stays up while a pop and a
  // push meet.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count <= '0;
      token_done_flag <= 1'b0;
      stat_full <= 1'b0;
    end else begin
      count <= next_count;
      token_done_flag <= (next_count != '0);
      stat_full <= (next_count == FULL);
    end
  end

  // ****************************************
  // Control register
  // ****************************************

  // Live receiver levels, sampled once so a read sees a stable value.
  // Polarity of the J level flips with the low speed setting, because
  // the idle line swaps its levels at low speed.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      live_j_level <= 1'b0;
      live_se0 <= 1'b0;
    end else begin
      live_j_level <= rx_j_raw ^ low_speed_select;
      live_se0 <= rx_se0;
    end
  end

  // Plain software bits.
  // The mode bit is read straight from its flip-flop; every level that
  // depends on it settles one cycle later.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reset_bit <= usb_esc_pkg::CTL_RESET[usb_esc_pkg::CTL_RESET_SIG];
      host_role_select <= usb_esc_pkg::CTL_RESET[usb_esc_pkg::CTL_HOST];
      resume_bit <= usb_esc_pkg::CTL_RESET[usb_esc_pkg::CTL_RESUME];
      enable_bit <= usb_esc_pkg::CTL_RESET[usb_esc_pkg::CTL_ENABLE];
    end else if (wr_ctl) begin
      reset_bit <= reg_req.wdata[usb_esc_pkg::CTL_RESET_SIG];
      host_role_select <= reg_req.wdata[usb_esc_pkg::CTL_HOST];
      resume_bit <= reg_req.wdata[usb_esc_pkg::CTL_RESUME];
      enable_bit <= reg_req.wdata[usb_esc_pkg::CTL_ENABLE];
    end
  end

  // Busy in host mode tracks the engine; suspend in target mode is sticky.
  // In target mode a write that leaves bit 5 at 0 resumes traffic, so
  // software must write 1 there when it only means to change another bit.
  // A SETUP in the same cycle as such a write wins.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_or_suspend_flag <= 1'b0;
    end else if (host_role_select) begin
      busy_or_suspend_flag <= token_busy;
    end else if (setup_rx) begin
      busy_or_suspend_flag <= 1'b1;
    end else if (wr_ctl && !reg_req.wdata[usb_esc_pkg::CTL_BUSY]) begin
      busy_or_suspend_flag <= 1'b0;
    end
  end

  // ****************************************
  // Engine control outputs
  // ****************************************

  // Signalling levels follow the stored bits one cycle later.
  // Reset signalling and the low speed token are owed only in host mode,
  // so both are gated by the mode bit here rather than in the engine.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      drive_usb_reset <= 1'b0;
      drive_resume <= 1'b0;
      module_enable_frame_gen <= 1'b0;
      sof_enable <= 1'b0;
      traffic_halt <= 1'b0;
      low_speed_token <= 1'b0;
    end else begin
      drive_usb_reset <= host_role_select && reset_bit;
      drive_resume <= resume_bit;
      module_enable_frame_gen <= enable_bit;
      sof_enable <= host_role_select && enable_bit;
      traffic_halt <= !host_role_select && busy_or_suspend_flag;
      low_speed_token <= host_role_select && low_speed_select;
    end
  end

  // One-cycle pulses. The end of packet is only owed on a falling resume.
  // A write that sets the enable bit clears the bank bits as well, so the
  // engine always restarts on the even bank.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ls_eop_pulse <= 1'b0;
      bank_select_clear <= 1'b0;
      engine_reset_pulse <= 1'b0;
    end else begin
      ls_eop_pulse <= wr_ctl && host_role_select && resume_bit &&
                      !reg_req.wdata[usb_esc_pkg::CTL_RESUME];
      bank_select_clear <= wr_ctl &&
        (reg_req.wdata[usb_esc_pkg::CTL_BANK_CLR] ||
         (reg_req.wdata[usb_esc_pkg::CTL_ENABLE] && !enable_bit));
      engine_reset_pulse <= wr_ctl && !enable_bit &&
                            reg_req.wdata[usb_esc_pkg::CTL_ENABLE];
    end
  end

  // ****************************************
  // Read port
  // ****************************************

  // Data stand only in the cycle after the strobe; unmapped reads give 0.
  // Status reads show the queue head without popping it; the pop is a
  // separate write so that software can read the entry more than once.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        usb_esc_pkg::ADDR_IRQ_STATUS: begin
          reg_rdata <= 8'h00;
          reg_rdata[usb_esc_pkg::IRQ_STATUS_TOK_DONE] <= token_done_flag;
          reg_rdata[usb_esc_pkg::IRQ_STATUS_ERROR] <= error_irq;
        end
        usb_esc_pkg::ADDR_ERR_FLAGS: begin
          reg_rdata <= error_flag_register;
        end
        usb_esc_pkg::ADDR_ERREN: begin
          reg_rdata <= error_irq_enable;
        end
        usb_esc_pkg::ADDR_STAT: begin
          reg_rdata <= {queue[rd_ptr].endpoint, queue[rd_ptr].tx,
                        queue[rd_ptr].odd, 2'b00};
        end
        usb_esc_pkg::ADDR_CTL: begin
          reg_rdata <= {live_j_level, live_se0, busy_or_suspend_flag,
                        reset_bit, host_role_select, resume_bit, 1'b0,
                        enable_bit};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : usb_error_status_control

// ### test/usb_esc_checker.sv
`timescale 1ns/10ps
// ****************************************
// Port checker
// ****************************************
module usb_esc_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port.
  input wire usb_esc_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Queue and interrupt.
  input wire logic stat_push,
  input wire logic token_done_flag,
  input wire logic error_irq,
  // Engine controls.
  input wire logic host_role_select,
  input wire logic drive_usb_reset,
  input wire logic drive_resume,
  input wire logic ls_eop_pulse,
  input wire logic bank_select_clear,
  input wire logic engine_reset_pulse,
  input wire logic module_enable_frame_gen,
  input wire logic sof_enable,
  input wire logic traffic_halt,
  input wire logic low_speed_token
);
  // One clock domain, so clock and reset are given once here.
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Read data must not linger, or stale status could be mistaken.
  chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data seen without a read");
  chk_stat_low: assert property (reg_req.rd &&
    reg_req.addr == usb_esc_pkg::ADDR_STAT |=> reg_rdata[1:0] == 2'h0)
    else $error("status low bits not zero");
  chk_push_flag: assert property (stat_push |=> token_done_flag)
    else $error("push did not raise token done");
  chk_pop_cause: assert property ($fell(token_done_flag) |->
    $past(reg_req.wr)) else $error("token done fell without a write");
  chk_irq_cause: assert property ($fell(error_irq) |->
    $past(reg_req.wr, 2)) else $error("error request fell by itself");
  // Engine levels lag the mode bit by one cycle, so they are held
  // against the mode bit's previous value.
  chk_sof_host: assert property (sof_enable |->
    $past(host_role_select) && module_enable_frame_gen)
    else $error("frame start outside host");
  chk_halt_target: assert property (traffic_halt |->
    !$past(host_role_select)) else $error("traffic halted in host mode");
  chk_bus_reset: assert property (drive_usb_reset |->
    $past(host_role_select)) else $error("bus reset driven in target mode");
  chk_eop_resume: assert property (ls_eop_pulse |=> !drive_resume)
    else $error("end of packet while resume still driven");
  chk_enable_rise: assert property (engine_reset_pulse |->
    bank_select_clear ##1 module_enable_frame_gen)
    else $error("enable did not clear banks");
  chk_low_speed: assert property (low_speed_token |->
    $past(host_role_select)) else $error("low speed token outside host");
endmodule : usb_esc_checker

bind usb_error_status_control usb_esc_checker u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .stat_push(stat_push), .token_done_flag(token_done_flag),
  .error_irq(error_irq), .host_role_select(host_role_select),
  .drive_usb_reset(drive_usb_reset), .drive_resume(drive_resume),
  .ls_eop_pulse(ls_eop_pulse), .bank_select_clear(bank_select_clear),
  .engine_reset_pulse(engine_reset_pulse), .sof_enable(sof_enable),
  .module_enable_frame_gen(module_enable_frame_gen),
  .traffic_halt(traffic_halt), .low_speed_token(low_speed_token));

// ### test/usb_engine_model.sv
`timescale 1ns/10ps
// ****************************************
// Serial engine and cable model
// ****************************************
module usb_engine_model (
  // Clock.
  input wire logic clk_sys,
  // Events and levels toward the block.
  output logic [7:0] err_event,
  output logic stat_push,
  output usb_esc_pkg::stat_entry_t stat_in,
  output logic token_busy,
  output logic setup_rx,
  output logic rx_j_raw,
  output logic rx_se0,
  output logic low_speed_select
);
  // Quiet line at time zero.
  initial begin
    {err_event, stat_push, stat_in, token_busy} = '0;
    {setup_rx, rx_j_raw, rx_se0, low_speed_select} = '0;
  end
  // An error is reported the cycle it is seen, not at token end.
  task automatic err(input int b);
    @(posedge clk_sys); err_event <= 8'h01 << b;
    @(posedge clk_sys); err_event <= 8'h00;
  endtask : err
  // Entry lines show the inverse once released, so stale data shows up.
  task automatic push(input usb_esc_pkg::stat_entry_t e);
    @(posedge clk_sys); stat_push <= 1'b1; stat_in <= e;
    @(posedge clk_sys); stat_push <= 1'b0; stat_in <= ~e;
  endtask : push
  task automatic setup();
    @(posedge clk_sys); setup_rx <= 1'b1;
    @(posedge clk_sys); setup_rx <= 1'b0;
  endtask : setup
  task automatic lines(input logic b, j, s, l);
    @(posedge clk_sys); token_busy <= b; rx_j_raw <= j;
    rx_se0 <= s; low_speed_select <= l;
  endtask : lines
endmodule : usb_engine_model

// ### test/tb.sv
`timescale 1ns/10ps
// ****************************************
// Testbench top
// ****************************************
module tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  usb_esc_pkg::reg_req_t req = '0;
  logic [7:0] rdata, err_event;
  logic push, busy, setup, j, se0, ls, full, irq, tok, host, urst, res;
  logic eop, bclr, erst, en, sof, halt, lst;
  usb_esc_pkg::stat_entry_t entry;
  int num_errors = 0;
  int comparisons = 0;

  usb_engine_model u_eng (.clk_sys(clk_sys), .err_event(err_event),
    .stat_push(push), .stat_in(entry), .token_busy(busy),
    .setup_rx(setup), .rx_j_raw(j), .rx_se0(se0), .low_speed_select(ls));
  usb_error_status_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .err_event(err_event),
    .stat_push(push), .stat_in(entry), .token_busy(busy), .setup_rx(setup),
    .rx_j_raw(j), .rx_se0(se0), .low_speed_select(ls), .stat_full(full),
    .error_irq(irq), .token_done_flag(tok), .host_role_select(host),
    .drive_usb_reset(urst), .drive_resume(res), .ls_eop_pulse(eop),
    .bank_select_clear(bclr), .engine_reset_pulse(erst),
    .module_enable_frame_gen(en), .sof_enable(sof), .traffic_halt(halt),
    .low_speed_token(lst));

  // Clock at 250 MHz.
  always #2 clk_sys = ~clk_sys;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic chk_byte(input string w, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : chk_byte
  task automatic chk_bit(input string w, input logic e, g);
    chk_byte(w, {7'h00, e}, {7'h00, g});
  endtask : chk_bit
  // Strobes last one cycle; the caller sits one ns past the taking edge.
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys); req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys); req.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, e, input string w);
    @(posedge clk_sys); req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys); req.rd <= 1'b0;
    #1;
    chk_byte(w, e, rdata);
  endtask : rd
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // Main sequence; the block holds no long counts, so it runs short.
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(1);
    rd(usb_esc_pkg::ADDR_ERREN, 8'h00, "enable reset");
    rd(usb_esc_pkg::ADDR_CTL, 8'h00, "control reset");
    rd(8'hF0, 8'h00, "unmapped");
    wr(usb_esc_pkg::ADDR_ERREN, 8'hFF);
    rd(usb_esc_pkg::ADDR_ERREN, 8'hBF, "enable mask");
    $display("test registers done");
    for (int b = 0; b < 8; b++) if (b != 6) begin
      wr(usb_esc_pkg::ADDR_ERREN, 8'h00);
      u_eng.err(b);
      tick(2);
      chk_bit("irq masked", 1'b0, irq);
      rd(usb_esc_pkg::ADDR_ERR_FLAGS, 8'h01 << b, "flag");
      wr(usb_esc_pkg::ADDR_ERREN, 8'h01 << b);
      tick(1);
      chk_bit("irq on", 1'b1, irq);
      rd(usb_esc_pkg::ADDR_IRQ_STATUS, 8'h02, "error bit");
      wr(usb_esc_pkg::ADDR_ERR_FLAGS, 8'h01 << b);
      tick(1);
      chk_bit("irq off", 1'b0, irq);
    end
    $display("test errors done");
    for (int i = 0; i < 5; i++) begin
      u_eng.push('{4'(i + 9), i[0], i[1]});
    end
    tick(1);
    chk_bit("full", 1'b1, full);
    for (int i = 0; i < 4; i++) begin
      chk_bit("token done", 1'b1, tok);
      rd(usb_esc_pkg::ADDR_STAT, {4'(i + 9), i[0], i[1], 2'h0}, "stat");
      wr(usb_esc_pkg::ADDR_IRQ_STATUS, 8'h08);
    end
    chk_bit("drained", 1'b0, tok);
    $display("test queue done");
    u_eng.lines(1'b1, 1'b1, 1'b0, 1'b0);
    wr(usb_esc_pkg::ADDR_CTL, 8'h09);
    chk_bit("engine reset", 1'b1, erst);
    tick(1);
    chk_bit("frame start", 1'b1, sof);
    chk_bit("module on", 1'b1, en);
    rd(usb_esc_pkg::ADDR_CTL, 8'hA9, "busy j");
    u_eng.lines(1'b0, 1'b1, 1'b1, 1'b1);
    tick(2);
    rd(usb_esc_pkg::ADDR_CTL, 8'h49, "j se0");
    chk_bit("low speed", 1'b1, lst);
    wr(usb_esc_pkg::ADDR_CTL, 8'h19);
    tick(1);
    chk_bit("bus reset", 1'b1, urst);
    wr(usb_esc_pkg::ADDR_CTL, 8'h0D);
    tick(1);
    chk_bit("resume", 1'b1, res);
    wr(usb_esc_pkg::ADDR_CTL, 8'h0B);
    chk_bit("eop", 1'b1, eop);
    chk_bit("bank clear", 1'b1, bclr);
    wr(usb_esc_pkg::ADDR_CTL, 8'h08);
    tick(1);
    chk_bit("frame stop", 1'b0, sof);
    chk_bit("module off", 1'b0, en);
    wr(usb_esc_pkg::ADDR_CTL, 8'h11);
    u_eng.setup();
    tick(2);
    chk_bit("halt", 1'b1, halt);
    chk_bit("no reset", 1'b0, urst);
    rd(usb_esc_pkg::ADDR_CTL, 8'h71, "suspend");
    wr(usb_esc_pkg::ADDR_CTL, 8'h01);
    tick(1);
    chk_bit("resume traffic", 1'b0, halt);
    $display("test control done");
    wrap_up();
  end

  // The tests need about 190 cycles; this cuts off a hang.
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end
endmodule : tb
